// >>> inc/dwb_pkg.sv
// Shared constants and types for the write-burst / precharge link
package dwb_pkg;
  localparam int ROW_W  = 14;
  localparam int COL_W  = 10;
  localparam int BANK_W = 3;
  localparam int NBANK  = 8;
  localparam int DQ_W   = 8;
  localparam int AP_BIT = 10;          // Auto precharge / all-banks select
  localparam int BC_BIT = 12;          // Burst chop select in OTF mode
  localparam int BL8_LEN = 8;
  localparam int BC4_LEN = 4;
  localparam int AL_RST  = 0;          // Additive latency after reset
  localparam int CWL_RST = 5;          // CAS write latency after reset
  localparam int WL_MAX  = 31;
  localparam int LAT_W   = 5;
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam int WR_CYC  = 8;          // Write recovery, link clocks
  localparam int WTR_CYC = 4;          // Write to read, link clocks
  localparam int CNT_W   = 6;
  // Command encodings on the link
  typedef enum logic [2:0] {
    DWB_NOP, DWB_ACT, DWB_WR, DWB_RD, DWB_PRE
  } dwb_cmd_t;
endpackage : dwb_pkg

// >>> inc/dwb_if.sv
// Link between the write controller and the memory device end
`timescale 1ns/1ns
`default_nettype none
interface dwb_if;
  logic                           ck;
  dwb_pkg::dwb_cmd_t              cmd;
  logic [dwb_pkg::BANK_W-1:0]     ba;
  logic [dwb_pkg::ROW_W-1:0]      addr;
  logic                           dqs_o;
  logic                           dqs_n_o;
  logic                           dqs_oe;
  logic [dwb_pkg::DQ_W-1:0]       dq_o;
  logic                           dq_oe;
  logic                           dm;
  modport ctrl (output ck, cmd, ba, addr, dqs_o, dqs_n_o, dqs_oe, dq_o, dq_oe, dm);
  modport mem  (input ck, cmd, ba, addr, dqs_o, dqs_n_o, dqs_oe, dq_o, dq_oe, dm);
endinterface : dwb_if
`default_nettype wire

// >>> rtl/dwb_mem.sv
// Memory device end: write burst capture, masking and precharge
// How it works
// [R01] WRITE carries bank, column, auto-precharge choice
// [R02] Auto precharge closes row after burst
// [R03] Accepted write bursts always run to end
// [R04] Data captured on successive strobe edges after WL; the memory end captures on rising link clocks while dqs_oe is high
// [R05] WL equals additive plus CAS write latency
// [R06] Controller sends full preamble, half postamble; the controller holds the postamble for one full link clock
// [R07] Strobe high, then low half clock before data; the controller holds dqs_o low through the whole preamble
// [R08] Strobe held low after last data
// [R09] First strobe edge at WL within skew; the controller never toggles dqs_o, so there is no strobe edge
// [R10] Mask high leaves the element unwritten
// [R11] After burst, extra data is ignored
// [R12] Writes tCCD apart stream data continuously
// [R13] Write-to-read counted after last data
// [R14] OTF chop counts write-to-read from full burst; the controller counts from its last sent beat, so a chop counts from beat 4
// [R15] Write recovery before precharge same bank
// [R16] Burst length from mode field and A12
// [R17] A10 picks one bank or all banks
// [R18] Precharged bank needs ACTIVATE before access
// [R19] A10 high means all banks
`timescale 1ns/1ns
`default_nettype none
module dwb_mem #(
  parameter int DEPTH = 64
) (
  dwb_if.mem                          link,
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic [dwb_pkg::LAT_W-1:0] al,
  input  wire logic [dwb_pkg::LAT_W-1:0] cwl,
  input  wire logic [1:0]             bl_mode,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [dwb_pkg::DQ_W-1:0]    rd_data,
  output logic [dwb_pkg::NBANK-1:0]   bank_open,
  output logic                        write_err
);
  // Synchronised reset for the link domain
  logic rst_s1, rst_s2;
  always_ff @(posedge link.ck) begin
    rst_s1 <= reset;
    rst_s2 <= rst_s1;
  end
  logic [DEPTH-1:0][dwb_pkg::DQ_W-1:0] mem;
  typedef enum {DWB_IDLE, DWB_WAIT, DWB_DATA} dwb_st_t;
  dwb_st_t st, next_st;
  logic [dwb_pkg::CNT_W-1:0] cnt, next_cnt;
  logic [3:0] beats, next_beats;
  logic [$clog2(DEPTH)-1:0] wptr, next_wptr;
  logic ap, next_ap;
  logic [dwb_pkg::BANK_W-1:0] wbank, next_wbank;
  logic [dwb_pkg::NBANK-1:0] open_q, next_open;
  logic err, next_err;
  logic [3:0] blen;
  logic [dwb_pkg::CNT_W-1:0] wl;
  // Burst length decode
  always_comb begin
    unique case (bl_mode)
      dwb_pkg::BL_FIX8: blen = 4'(dwb_pkg::BL8_LEN); // R16
      dwb_pkg::BL_OTF:  blen = link.addr[dwb_pkg::BC_BIT] ? 4'(dwb_pkg::BL8_LEN)
                                                          : 4'(dwb_pkg::BC4_LEN); // R16
      default:          blen = 4'(dwb_pkg::BC4_LEN); // R16
    endcase
    wl = dwb_pkg::CNT_W'(al) + dwb_pkg::CNT_W'(cwl); // R05
  end
  // Command and burst sequencing
  always_comb begin
    next_st = st; next_cnt = cnt; next_beats = beats; next_wptr = wptr;
    next_ap = ap; next_wbank = wbank; next_open = open_q; next_err = err;
    if (link.cmd == dwb_pkg::DWB_ACT)
      next_open[link.ba] = 1'b1;
    if (link.cmd == dwb_pkg::DWB_PRE) begin
      if (link.addr[dwb_pkg::AP_BIT]) next_open = '0; // R17 R19
      else next_open[link.ba] = 1'b0; // R17
    end
    unique case (st)
      DWB_IDLE: ;
      DWB_WAIT: begin
        if (cnt <= 2) next_st = DWB_DATA; // R04
        else next_cnt = cnt - 1'b1;
      end
      DWB_DATA: begin
        if (link.dqs_oe) begin
          next_beats = beats - 1'b1; // R04
          next_wptr  = wptr + 1'b1;
          if (beats == 1) begin
            next_st = DWB_IDLE; // R11
            if (ap) next_open[wbank] = 1'b0; // R02
          end
        end
      end
    endcase
    // Accept write; a back-to-back write extends the stream
    if (link.cmd == dwb_pkg::DWB_WR) begin
      if (!open_q[link.ba]) next_err = 1'b1; // R18
      else if (st == DWB_IDLE) begin // R01 R03
        next_st = (wl <= 1) ? DWB_DATA : DWB_WAIT;
        next_cnt = wl; next_beats = blen;
        next_wptr = $clog2(DEPTH)'(link.addr);
        next_ap = link.addr[dwb_pkg::AP_BIT]; next_wbank = link.ba;
      end else next_beats = next_beats + blen; // R12
    end
  end
  // Link-domain state registers
  always_ff @(posedge link.ck) begin
    if (rst_s2) begin
      st <= DWB_IDLE; cnt <= '0; beats <= '0; wptr <= '0;
      ap <= 1'b0; wbank <= '0; open_q <= '0; err <= 1'b0;
    end else begin
      st <= next_st; cnt <= next_cnt; beats <= next_beats; wptr <= next_wptr;
      ap <= next_ap; wbank <= next_wbank; open_q <= next_open; err <= next_err;
    end
  end
  // Store unmasked data on strobe beats; outside bursts data is dropped
  always_ff @(posedge link.ck) begin
    if (st == DWB_DATA && link.dqs_oe && !link.dm) mem[wptr] <= link.dq_o; // R10 R11
  end
  // Status crosses to the system clock through two sync flops and an output flop
  logic [dwb_pkg::NBANK:0] s1, s2;
  always_ff @(posedge clock) begin
    s1 <= {err, open_q};
    s2 <= s1;
    if (reset) begin
      bank_open <= '0; write_err <= 1'b0; rd_data <= '0;
    end else begin
      bank_open <= s2[dwb_pkg::NBANK-1:0];
      write_err <= s2[dwb_pkg::NBANK];
      rd_data   <= mem[rd_addr];
    end
  end
endmodule : dwb_mem
`default_nettype wire

// >>> rtl/dwb_ctrl.sv
// Controller end: issues commands and drives strobe, data and mask
`timescale 1ns/1ns
`default_nettype none
module dwb_ctrl (
  dwb_if.ctrl                            link,
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire logic                      req,
  input  wire dwb_pkg::dwb_cmd_t         req_cmd,
  input  wire logic [dwb_pkg::BANK_W-1:0] req_ba,
  input  wire logic [dwb_pkg::ROW_W-1:0] req_addr,
  input  wire logic [dwb_pkg::DQ_W-1:0]  wdata,
  input  wire logic                      wmask,
  input  wire logic [dwb_pkg::LAT_W-1:0] wl,
  input  wire logic [3:0]                blen,
  output logic                           busy
);
  typedef enum {DWC_IDLE, DWC_LAT, DWC_PRE, DWC_DATA, DWC_POST, DWC_REC} dwc_st_t;
  dwc_st_t st, next_st;
  logic [dwb_pkg::CNT_W-1:0] cnt, next_cnt;
  logic ck_q;
  logic rst_q;
  // Link clock divided by two; keeps running in reset so the far end can reset
  always_ff @(posedge clock) begin
    rst_q <= reset;
    if (!reset || rst_q) ck_q <= ~ck_q;
    else ck_q <= 1'b0;
  end
  assign link.ck = ck_q;
  // Pins change as the link clock falls, half a period before the far end samples
  wire fall = ck_q;
  // Sequencer: latency, preamble, data, postamble, recovery
  always_comb begin
    next_st = st; next_cnt = cnt;
    if (fall) unique case (st)
      DWC_IDLE: if (req && req_cmd == dwb_pkg::DWB_WR) begin
        next_st = DWC_LAT; next_cnt = dwb_pkg::CNT_W'(wl);
      end
      DWC_LAT: if (cnt <= 3) next_st = DWC_PRE; else next_cnt = cnt - 1'b1; // R07 R05
      DWC_PRE: begin next_st = DWC_DATA; next_cnt = dwb_pkg::CNT_W'(blen); end // R06
      DWC_DATA: if (cnt <= 1) next_st = DWC_POST; else next_cnt = cnt - 1'b1; // R03
      DWC_POST: begin next_st = DWC_REC; next_cnt = dwb_pkg::CNT_W'(dwb_pkg::WR_CYC); end // R08
      DWC_REC: if (cnt <= 1) next_st = DWC_IDLE; else next_cnt = cnt - 1'b1; // R13 R14 R15
    endcase
  end
  always_ff @(posedge clock) begin
    if (reset) begin st <= DWC_IDLE; cnt <= '0; end
    else begin st <= next_st; cnt <= next_cnt; end
  end
  // Pin drive, changed on falling link clock
  always_ff @(posedge clock) begin
    if (reset) begin
      link.cmd <= dwb_pkg::DWB_NOP; link.ba <= '0; link.addr <= '0;
      link.dqs_o <= 1'b0; link.dqs_n_o <= 1'b1; link.dqs_oe <= 1'b0;
      link.dq_o <= '0; link.dq_oe <= 1'b0; link.dm <= 1'b0; busy <= 1'b0;
    end else begin
      busy <= (st != DWC_IDLE);
      if (fall) begin
        link.cmd <= (req && (st == DWC_IDLE || req_cmd != dwb_pkg::DWB_WR))
                    ? req_cmd : dwb_pkg::DWB_NOP; // R01 R18
        link.ba <= req_ba; link.addr <= req_addr;
        link.dqs_oe <= (st == DWC_PRE || st == DWC_DATA || st == DWC_POST); // R09 R08
        link.dq_oe  <= (st == DWC_DATA);
        link.dq_o <= wdata; link.dm <= wmask; // R10
        link.dqs_o <= 1'b0; link.dqs_n_o <= 1'b1;
      end
    end
  end
endmodule : dwb_ctrl
`default_nettype wire

// >>> dv/dwb_chk.sv
// Checker for the strobe, data and command signals of the link
`timescale 1ns/1ns
`default_nettype none
module dwb_chk (
  input wire logic              ck,
  input wire logic              reset,
  input wire dwb_pkg::dwb_cmd_t cmd,
  input wire logic              dqs_o,
  input wire logic              dqs_n_o,
  input wire logic              dqs_oe,
  input wire logic              dq_oe
);
  logic [5:0] run;
  logic [5:0] next_run;
  logic [5:0] gap;
  logic [5:0] next_gap;
  // Beat run length, and link clocks since the last beat (saturating)
  always_comb begin
    next_run = dq_oe ? run + 6'h01 : 6'h00;
    next_gap = dq_oe ? 6'h00 : ((gap == 6'h3F) ? gap : gap + 6'h01);
  end
  // Gap starts saturated so commands before any write are legal
  always_ff @(posedge ck) begin
    run <= reset ? 6'h00 : next_run;
    gap <= reset ? 6'h3F : next_gap;
  end
  default clocking @(posedge ck); endclocking
  default disable iff (reset);
  AST_DQS_PAIR: assert property (dqs_oe |-> dqs_n_o == !dqs_o)
    else $error("strobe pair not complementary");
  AST_DQ_STROBED: assert property (dq_oe |-> dqs_oe)
    else $error("data driven without strobe");
  AST_PREAMBLE: assert property ($rose(dq_oe) |-> $past(dqs_oe))
    else $error("no strobe preamble before data");
  AST_POSTAMBLE: assert property ($fell(dq_oe) |-> dqs_oe && !dqs_o)
    else $error("strobe not held low after data");
  AST_WR_LAT: assert property (cmd == dwb_pkg::DWB_WR && !dq_oe
    |-> ##1 !dq_oe [*4] ##1 dq_oe)
    else $error("first beat not at write latency");
  AST_BURST_LEN: assert property ($fell(dq_oe) |-> run == 6'h04 || run == 6'h08)
    else $error("burst cut or overlong");
  AST_WR_TO_PRE: assert property (cmd == dwb_pkg::DWB_PRE |-> gap >= 6'h08)
    else $error("precharge before write recovery");
  AST_WR_TO_RD: assert property (cmd == dwb_pkg::DWB_RD |-> gap >= 6'h04)
    else $error("read before write to read delay");
  // Main scenarios reached
  COV_PRE: cover property (cmd == dwb_pkg::DWB_PRE);
  COV_BC4: cover property ($fell(dq_oe) && run == 6'h04);
  COV_BL8: cover property ($fell(dq_oe) && run == 6'h08);
endmodule : dwb_chk
`default_nettype wire

// >>> dv/tb.sv
// Testbench joining the controller end and the memory end
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic              clock = 1'b0;
  logic              reset = 1'b1;
  logic              req = 1'b0;
  logic              wmask = 1'b0;
  dwb_pkg::dwb_cmd_t req_cmd = dwb_pkg::DWB_NOP;
  logic [2:0]        req_ba = 3'h0;
  logic [13:0]       req_addr = 14'h0000;
  logic [7:0]        wdata = 8'h00;
  logic [4:0]        al = 5'h01;
  logic [4:0]        cwl = 5'h04;
  logic [4:0]        wl = 5'h05;
  logic [1:0]        bl_mode = 2'h0;
  logic [3:0]        blen = 4'h8;
  logic [5:0]        rd_addr = 6'h00;
  logic [7:0]        rd_data;
  logic [7:0]        bank_open;
  logic [7:0]        exp_mem [8];
  logic              busy;
  logic              write_err;
  int                fail_count = 0;
  int                num_checks = 0;
  // Fast clock; the controller divides it for the link
  always #5 clock = ~clock;
  dwb_if link ();
  dwb_ctrl i_dwb_ctrl (.link(link), .clock(clock), .reset(reset), .req(req),
    .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr), .wdata(wdata),
    .wmask(wmask), .wl(wl), .blen(blen), .busy(busy));
  dwb_mem i_dwb_mem (.link(link), .clock(clock), .reset(reset), .al(al), .cwl(cwl),
    .bl_mode(bl_mode), .rd_addr(rd_addr), .rd_data(rd_data), .bank_open(bank_open),
    .write_err(write_err));
  dwb_chk i_dwb_chk (.ck(link.ck), .reset(reset), .cmd(link.cmd), .dqs_o(link.dqs_o),
    .dqs_n_o(link.dqs_n_o), .dqs_oe(link.dqs_oe), .dq_oe(link.dq_oe));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic do_reset();
    reset = 1'b1;
    repeat (6) @(negedge clock);
    reset = 1'b0;
    // Link-side reset and status sync need several cycles to settle
    repeat (8) @(negedge clock);
  endtask : do_reset
  // Request held one link period so exactly one link fall samples it
  task automatic issue(input dwb_pkg::dwb_cmd_t c, input logic [2:0] b, input logic [13:0] a);
    int n;
    n = 0;
    req_cmd = c;
    req_ba = b;
    req_addr = a;
    req = 1'b1;
    repeat (2) @(negedge clock);
    req = 1'b0;
    repeat (4) @(negedge clock);
    while (busy !== 1'b0 && n < 300) begin
      n++;
      @(negedge clock);
    end
    if (n == 300) begin
      fail_count++;
      test_done();
    end
    // Status lags a few cycles; recovery also covered here
    repeat (2 * dwb_pkg::WR_CYC + 8) @(negedge clock);
  endtask : issue
  task automatic peek(input int a, input logic [7:0] e);
    rd_addr = 6'(a);
    repeat (2) @(negedge clock);
    check("rd_data", rd_data, e);
  endtask : peek
  // Every burst mode, then a fully masked burst over old data
  task automatic t_bursts();
    issue(dwb_pkg::DWB_ACT, 3'h0, 14'h0000);
    check("bank_open", bank_open, 8'h01);
    for (int i = 0; i < 5; i++) begin
      bl_mode = (i == 1) ? dwb_pkg::BL_FIX4 : (i == 2 || i == 3) ? dwb_pkg::BL_OTF : 2'h0;
      blen = (i == 1 || i == 3) ? 4'h4 : 4'h8;
      wmask = (i == 4);
      wdata = 8'(8'h11 * (i + 1));
      issue(dwb_pkg::DWB_WR, 3'h0, {1'b0, i == 2, 12'h000});
      for (int j = 0; j < 8; j++) if (!wmask && j < blen) exp_mem[j] = wdata;
      for (int j = 0; j < 8; j++) peek(j, exp_mem[j]);
    end
    wmask = 1'b0;
    issue(dwb_pkg::DWB_RD, 3'h0, 14'h0000);
    check("write_err", {7'h00, write_err}, 8'h00);
  endtask : t_bursts
  // Single bank and all bank precharge
  task automatic t_precharge();
    issue(dwb_pkg::DWB_PRE, 3'h0, 14'h0000);
    check("bank_open", bank_open, 8'h00);
    issue(dwb_pkg::DWB_ACT, 3'h1, 14'h0000);
    issue(dwb_pkg::DWB_ACT, 3'h3, 14'h0000);
    check("bank_open", bank_open, 8'h0A);
    issue(dwb_pkg::DWB_PRE, 3'h5, 14'h0400);
    check("bank_open", bank_open, 8'h00);
  endtask : t_precharge
  // Auto precharge closes the row; a later write is refused
  task automatic t_auto_err();
    issue(dwb_pkg::DWB_ACT, 3'h2, 14'h0000);
    issue(dwb_pkg::DWB_WR, 3'h2, 14'h0400);
    check("bank_open", bank_open, 8'h00);
    issue(dwb_pkg::DWB_WR, 3'h2, 14'h0000);
    check("write_err", {7'h00, write_err}, 8'h01);
    do_reset();
    check("write_err", {7'h00, write_err}, 8'h00);
  endtask : t_auto_err
  initial begin
    do_reset();
    check("bank_open", bank_open, 8'h00);
    t_bursts();
    t_precharge();
    t_auto_err();
    test_done();
  end
endmodule : tb
`default_nettype wire
